// File: hdl/wcp_params.svh
// constants and register map of the wavefront centroid pipeline
// Functional notes
// - centroid is weighted sum of 4x4 pixels
// - centroid modes chosen purely by weight values
// - link word holds two 12-bit pixels
// - results leave packed in 24-bit words
// - subtract loaded dark value per pixel first
// - scale each pixel by loaded flat-field gain
// - threshold, centroid, subtract reference centroids
// - tip/tilt averaged, subtracted from every centroid
// - tip/tilt-removed centroids drive wavefront reconstruction
// - tip/tilt value drives mirror output
// - tip/tilt-removed centroids go to telemetry
// - every stage forceable, every stage capturable
// - averaged offload data, programmable averaging length
// - full output frame sent within 50 us
// - supports 32x32 and 64x64 subaperture layouts
// - natural-star mode: 32x32, natural-star camera input
// - sustain 2 kHz frames without drops
// - camera-to-centroid latency below 50 us
`ifndef WCP_PARAMS_SVH
`define WCP_PARAMS_SVH
`define WCP_CLK_MHZ  200
`define WCP_XFER_US  50
`define WCP_XFER_CYC (`WCP_XFER_US * `WCP_CLK_MHZ)
`define WCP_NSUB     4096
`define WCP_A_CTRL   8'h00
`define WCP_A_THR    8'h04
`define WCP_A_FRC    8'h08
`define WCP_A_LIDX   8'h0c
`define WCP_A_DARK   8'h10
`define WCP_A_GAIN   8'h14
`define WCP_A_REF    8'h18
`define WCP_A_CAP    8'h1c
`define WCP_A_STAT   8'h20
`define WCP_A_TT     8'h24
`define WCP_A_CAP0   8'h28
`define WCP_A_AVG0   8'h38
`define WCP_C_EN     0
`define WCP_C_S64    1
`define WCP_C_NAT    2
`define WCP_C_STBY   3
`define WCP_C_FPIX   4
`define WCP_C_FCEN   5
`define WCP_C_FTT    6
`define WCP_C_FWF    7
`define WCP_C_AVG    8
`define WCP_CTRL_RST 12'h002
`define WCP_OKAY     2'b00
`define WCP_SLVERR   2'b10
`endif

// File: hdl/wcp_pkg.sv
// types of the wavefront centroid pipeline
package wcp_pkg;
	typedef enum logic {RP_IDLE = 1'b0, RP_SEND = 1'b1} wcp_rp_type;
	typedef logic [23:0] wcp_word_type;
endpackage : wcp_pkg

// File: hdl/wcp_top.sv
// wavefront centroid pipeline with its AXI4-Lite register slave
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "wcp_params.svh"
module wcp_top #(
	parameter int NSUB     = `WCP_NSUB,
	parameter int XFER_CYC = `WCP_XFER_CYC
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire wcp_pkg::wcp_word_type cam_data,
	input  wire logic               cam_valid,
	input  wire logic               cam_fval,
	input  wire wcp_pkg::wcp_word_type nat_data,
	input  wire logic               nat_valid,
	input  wire logic               nat_fval,
	input  wire logic [7:0]         awaddr,
	input  wire logic [2:0]         awprot,
	input  wire logic               awvalid,
	output logic                    awready,
	input  wire logic [31:0]        wdata,
	input  wire logic [3:0]         wstrb,
	input  wire logic               wvalid,
	output logic                    wready,
	output logic [1:0]              bresp,
	output logic                    bvalid,
	input  wire logic               bready,
	input  wire logic [7:0]         araddr,
	input  wire logic [2:0]         arprot,
	input  wire logic               arvalid,
	output logic                    arready,
	output logic [31:0]             rdata,
	output logic [1:0]              rresp,
	output logic                    rvalid,
	input  wire logic               rready,
	output wcp_pkg::wcp_word_type   wf_data,
	output logic                    wf_valid,
	output wcp_pkg::wcp_word_type   tel_data,
	output logic                    tel_valid,
	output wcp_pkg::wcp_word_type   tt_x,
	output wcp_pkg::wcp_word_type   tt_y,
	output logic                    tt_valid
);
	import wcp_pkg::*;
	localparam int SW = $clog2(NSUB);
	// row start in the replay looks at six index bits
	if (NSUB < 64 || (NSUB & (NSUB - 1)) != 0 || XFER_CYC > 65535) begin : g_bad
		$error("NSUB must be a power of two >= 64 and XFER_CYC < 65536");
	end

	typedef struct packed {
		logic [51:0]              s1;
		logic [51:0]              s2;
		logic                     fv_d;
		logic [SW+2:0]            widx;
		logic                     pv;
		logic [1:0][11:0]         pp;
		logic [SW+2:0]            pw;
		logic [31:0]              psum;
		logic [31:0]              bg;
		logic signed [23:0]       sx;
		logic signed [23:0]       sy;
		logic                     cv;
		logic signed [23:0]       cx;
		logic signed [23:0]       cy;
		logic signed [35:0]       ax;
		logic signed [35:0]       ay;
		logic                     fe;
		wcp_rp_type               rp;
		logic [SW-1:0]            ri;
		logic signed [23:0]       ttx;
		logic signed [23:0]       tty;
		logic                     ttv;
		logic signed [35:0]       wx;
		logic [31:0]              wsum;
		logic                     ov;
		logic                     tv;
		logic [23:0]              ow;
		logic [23:0]              tw;
		logic [11:0]              ctrl;
		logic [11:0]              thr;
		logic [23:0]              fvv;
		logic [SW+2:0]            li;
		logic [15:0][15:0]        wgt;
		logic [3:0][31:0]         cap;
		logic [2:0][31:0]         acc;
		logic [2:0][31:0]         avg;
		logic [14:0]              ac;
		logic [15:0]              fcnt;
		logic [15:0]              xc;
		logic                     late;
		logic                     ovr;
		logic                     awr;
		logic                     bv;
		logic [1:0]               br;
		logic                     arr;
		logic                     rv;
		logic [31:0]              rd;
	} wcp_state_type;

	wcp_state_type st_r, st_nxt;
	logic [23:0] dark_mem [NSUB*8];
	logic [15:0] gain_mem [NSUB*8];
	logic [31:0] ref_mem [NSUB];
	logic [47:0] cbuf [NSUB];
	logic dk_we, gn_we, rf_we, cb_we, iv;
	logic [SW-1:0] cb_idx;
	logic [47:0] cb_d;

	function automatic logic signed [23:0] wmul(input logic [7:0] w, input logic [11:0] p);
		wmul = 24'($signed(w)) * 24'($signed({1'b0, p}));
	endfunction : wmul

	function automatic logic [11:0] sat12(input logic signed [35:0] v);
		if (v > 36'sh0_0000_07ff)
			sat12 = 12'h7ff;
		else if (v < -36'sh0_0000_0800)
			sat12 = 12'h800;
		else
			sat12 = v[11:0];
	endfunction : sat12

	always_comb begin
		logic [25:0] src;
		logic [11:0] raw, dk, df, pe, re, im;
		logic [19:0] gm;
		logic [3:0] i0;
		logic [SW-1:0] sub, last;
		logic signed [23:0] sxn, syn, cxn, cyn, rx, ry;
		logic signed [35:0] axn, ayn, wxn;
		logic [31:0] ws, sm;
		logic [2:0][31:0] vals;
		logic [14:0] lim;
		logic [47:0] q;
		logic s32, row0, run;
		src = '0;
		raw = '0; dk = '0; df = '0; pe = '0; re = '0; im = '0; gm = '0; i0 = '0;
		sub = '0; last = '0; sxn = '0; syn = '0; cxn = '0; cyn = '0; rx = '0; ry = '0;
		axn = '0; ayn = '0; wxn = '0; ws = '0; sm = '0; vals = '0; lim = '0; q = '0;
		s32 = 1'b0;
		row0 = 1'b0;
		run = 1'b0;
		st_nxt = st_r;
		dk_we = 1'b0;
		gn_we = 1'b0;
		rf_we = 1'b0;
		cb_we = 1'b0;
		cb_idx = '0;
		cb_d = '0;
		s32 = st_r.ctrl[`WCP_C_NAT] || !st_r.ctrl[`WCP_C_S64];
		last = s32 ? SW'(NSUB / 4 - 1) : SW'(NSUB - 1);
		// register slave: both write channels taken together, response next cycle
		if (st_r.bv && bready)
			st_nxt.bv = 1'b0;
		if (st_r.awr) begin
			st_nxt.awr = 1'b0;
			st_nxt.bv = 1'b1;
			st_nxt.br = `WCP_OKAY;
			if (&wstrb) begin
				unique case (awaddr)
					`WCP_A_CTRL: st_nxt.ctrl = wdata[11:0];
					`WCP_A_THR:  st_nxt.thr = wdata[11:0];
					`WCP_A_FRC:  st_nxt.fvv = wdata[23:0];
					`WCP_A_LIDX: st_nxt.li = wdata[SW+2:0];
					`WCP_A_DARK: dk_we = 1'b1;
					`WCP_A_GAIN: gn_we = 1'b1;
					`WCP_A_REF:  rf_we = 1'b1;
					`WCP_A_STAT: begin
						st_nxt.ovr = 1'b0;
						st_nxt.late = 1'b0;
					end
					`WCP_A_CAP: if (wdata[0]) begin
						st_nxt.cap[0] = {8'h00, st_r.pp};
						st_nxt.cap[1] = {st_r.cy[15:0], st_r.cx[15:0]};
						st_nxt.cap[2] = {st_r.tty[15:0], st_r.ttx[15:0]};
						st_nxt.cap[3] = {8'h00, st_r.ow};
					end
					default: if (awaddr[7:6] == 2'b10 && awaddr[1:0] == 2'b00)
						st_nxt.wgt[awaddr[5:2]] = wdata[15:0];
					else
						st_nxt.br = `WCP_SLVERR;
				endcase
				if (dk_we || gn_we || rf_we)
					st_nxt.li = st_r.li + 1'b1;
			end
		end else if (awvalid && wvalid && !st_r.bv)
			st_nxt.awr = 1'b1;
		if (st_r.rv && rready)
			st_nxt.rv = 1'b0;
		if (st_r.arr) begin
			st_nxt.arr = 1'b0;
			st_nxt.rv = 1'b1;
			st_nxt.rd = 32'h0000_0000;
			unique case (araddr)
				`WCP_A_CTRL: st_nxt.rd = {20'h0_0000, st_r.ctrl};
				`WCP_A_THR:  st_nxt.rd = {20'h0_0000, st_r.thr};
				`WCP_A_FRC:  st_nxt.rd = {8'h00, st_r.fvv};
				`WCP_A_LIDX: st_nxt.rd = 32'(st_r.li);
				`WCP_A_STAT: st_nxt.rd = {13'h0000, st_r.rp, st_r.late, st_r.ovr, st_r.fcnt};
				`WCP_A_TT:   st_nxt.rd = {st_r.tty[15:0], st_r.ttx[15:0]};
				default: begin
					if (araddr >= `WCP_A_CAP0 && araddr < `WCP_A_AVG0)
						st_nxt.rd = st_r.cap[2'(araddr[7:2] - 6'h0a)];
					else if (araddr >= `WCP_A_AVG0 && araddr < 8'h44)
						st_nxt.rd = st_r.avg[2'(araddr[7:2] - 6'h0e)];
					else if (araddr[7:6] == 2'b10)
						st_nxt.rd = {16'h0000, st_r.wgt[araddr[5:2]]};
				end
			endcase
		end else if (arvalid && !st_r.rv)
			st_nxt.arr = 1'b1;

		// replay of a finished frame, one subaperture per clock
		st_nxt.ov = 1'b0;
		st_nxt.tv = 1'b0;
		st_nxt.ttv = 1'b0;
		if (st_r.rp == RP_SEND) begin
			q = cbuf[st_r.ri];
			rx = $signed(q[23:0]) - st_r.ttx;
			ry = $signed(q[47:24]) - st_r.tty;
			row0 = s32 ? (st_r.ri[4:0] == 5'h00) : (st_r.ri[5:0] == 6'h00);
			// row-wise slope integration stands in for the full reconstructor
			wxn = (row0 ? 36'sh0_0000_0000 : st_r.wx) + 36'(rx);
			re = sat12(wxn);
			im = sat12(36'(ry));
			if (st_r.ctrl[`WCP_C_FWF])
				{im, re} = st_r.fvv;
			st_nxt.wx = wxn;
			st_nxt.ov = 1'b1;
			st_nxt.ow = {im, re};
			st_nxt.tv = 1'b1;
			st_nxt.tw = {sat12(36'(ry)), sat12(36'(rx))};
			ws = st_r.wsum + 32'($signed(re));
			st_nxt.wsum = ws;
			st_nxt.ri = st_r.ri + 1'b1;
			st_nxt.xc = st_r.xc + 1'b1;
			if (st_r.xc >= 16'(XFER_CYC))
				st_nxt.late = 1'b1;
			if (st_r.ri == last) begin
				st_nxt.rp = RP_IDLE;
				vals = {ws, 32'(st_r.ttx), st_r.bg};
				lim = 15'((32'h0000_0001 << st_r.ctrl[11:8]) - 1);
				for (int k = 0; k < 3; k++) begin
					sm = st_r.acc[k] + vals[k];
					if (st_r.ac == lim) begin
						st_nxt.avg[k] = 32'($signed(sm) >>> st_r.ctrl[11:8]);
						st_nxt.acc[k] = 32'h0000_0000;
					end else
						st_nxt.acc[k] = sm;
				end
				st_nxt.ac = (st_r.ac == lim) ? 15'h0000 : st_r.ac + 1'b1;
			end
		end

		// pixel stage: dark, gain, threshold, two lanes per link word
		st_nxt.s1 = {nat_fval, nat_valid, nat_data, cam_fval, cam_valid, cam_data};
		st_nxt.s2 = st_r.s1;
		src = st_r.ctrl[`WCP_C_NAT] ? st_r.s2[51:26] : st_r.s2[25:0];
		run = st_r.ctrl[`WCP_C_EN] && !st_r.ctrl[`WCP_C_STBY];
		iv = src[24] && src[25] && run;
		st_nxt.fv_d = src[25];
		if (!src[25])
			st_nxt.widx = '0;
		if (src[25] && !st_r.fv_d) begin
			st_nxt.psum = 32'h0000_0000;
			if (st_r.rp == RP_SEND)
				st_nxt.ovr = 1'b1;
		end
		st_nxt.pv = iv;
		st_nxt.pw = st_r.widx;
		if (iv) begin
			st_nxt.widx = st_r.widx + 1'b1;
			// first word may share its cycle with the frame start
			st_nxt.psum = ((src[25] && !st_r.fv_d) ? 32'h0000_0000 : st_r.psum)
				+ 32'(src[11:0]) + 32'(src[23:12]);
		end
		for (int l = 0; l < 2; l++) begin
			raw = src[l*12 +: 12];
			dk = dark_mem[st_r.widx][l*12 +: 12];
			df = (raw > dk) ? raw - dk : 12'h000;
			gm = 20'(df) * 20'(gain_mem[st_r.widx][l*8 +: 8]);
			pe = (|gm[19:16]) ? 12'hfff : gm[15:4];
			if (pe < st_r.thr)
				pe = 12'h000;
			if (st_r.ctrl[`WCP_C_FPIX])
				pe = st_r.fvv[11:0];
			st_nxt.pp[l] = pe;
		end

		// centroid stage: eight words make one 4x4 subaperture
		st_nxt.cv = 1'b0;
		st_nxt.fe = 1'b0;
		i0 = {st_r.pw[2:0], 1'b0};
		sub = st_r.pw[SW+2:3];
		if (st_r.pv) begin
			sxn = ((st_r.pw[2:0] == 3'h0) ? 24'sh00_0000 : st_r.sx)
				+ wmul(st_r.wgt[i0][7:0], st_r.pp[0]) + wmul(st_r.wgt[i0 | 4'h1][7:0], st_r.pp[1]);
			syn = ((st_r.pw[2:0] == 3'h0) ? 24'sh00_0000 : st_r.sy)
				+ wmul(st_r.wgt[i0][15:8], st_r.pp[0]) + wmul(st_r.wgt[i0 | 4'h1][15:8], st_r.pp[1]);
			st_nxt.sx = sxn;
			st_nxt.sy = syn;
			if (&st_r.pw[2:0]) begin
				cxn = sxn - 24'($signed(ref_mem[sub][15:0]));
				cyn = syn - 24'($signed(ref_mem[sub][31:16]));
				if (st_r.ctrl[`WCP_C_FCEN]) begin
					cxn = $signed(st_r.fvv);
					cyn = $signed(st_r.fvv);
				end
				st_nxt.cv = 1'b1;
				st_nxt.cx = cxn;
				st_nxt.cy = cyn;
				cb_we = 1'b1;
				cb_idx = sub;
				cb_d = {cyn, cxn};
				axn = st_r.ax + 36'(cxn);
				ayn = st_r.ay + 36'(cyn);
				st_nxt.ax = axn;
				st_nxt.ay = ayn;
				if (sub == last) begin
					st_nxt.fe = 1'b1;
					st_nxt.ttv = 1'b1;
					st_nxt.ax = '0;
					st_nxt.ay = '0;
					st_nxt.ttx = 24'(axn >>> (s32 ? SW - 2 : SW));
					st_nxt.tty = 24'(ayn >>> (s32 ? SW - 2 : SW));
					if (st_r.ctrl[`WCP_C_FTT]) begin
						st_nxt.ttx = $signed(st_r.fvv);
						st_nxt.tty = $signed(st_r.fvv);
					end
					st_nxt.bg = st_r.psum;
					st_nxt.fcnt = st_r.fcnt + 1'b1;
					st_nxt.rp = RP_SEND;
					st_nxt.ri = '0;
					st_nxt.xc = 16'h0000;
					st_nxt.wsum = 32'h0000_0000;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
			st_r.ctrl <= `WCP_CTRL_RST;
		end else
			st_r <= st_nxt;
	end

	// calibration tables and frame buffer have no reset; software loads the tables, the centroid stage fills the frame buffer
	always_ff @(posedge aclk) begin
		if (dk_we)
			dark_mem[st_r.li] <= wdata[23:0];
		if (gn_we)
			gain_mem[st_r.li] <= wdata[15:0];
		if (rf_we)
			ref_mem[st_r.li[SW-1:0]] <= wdata;
		if (cb_we)
			cbuf[cb_idx] <= cb_d;
	end

	assign awready = st_r.awr;
	assign wready = st_r.awr;
	assign bvalid = st_r.bv;
	assign bresp = st_r.br;
	assign arready = st_r.arr;
	assign rvalid = st_r.rv;
	assign rdata = st_r.rd;
	assign rresp = `WCP_OKAY;
	assign wf_data = st_r.ow;
	assign wf_valid = st_r.ov;
	assign tel_data = st_r.tw;
	assign tel_valid = st_r.tv;
	assign tt_x = st_r.ttx;
	assign tt_y = st_r.tty;
	assign tt_valid = st_r.ttv;

	default clocking cb_a @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_last_px;
		st_r.pv && (&st_r.pw[2:0]);
	endsequence
	sequence s_tt_then_out;
		st_r.ttv ##1 st_r.ov;
	endsequence
	pix_lat_a: assert property (iv |=> st_r.pv)
		else $error("pixel stage latency broken");
	pix_thr_a: assert property (st_r.pv && !$past(st_r.ctrl[`WCP_C_FPIX])
		|-> (st_r.pp[0] == 12'h000 || st_r.pp[0] >= $past(st_r.thr)))
		else $error("pixel below threshold passed");
	cen_grid_a: assert property (s_last_px |=> st_r.cv)
		else $error("centroid not formed after 4x4 block");
	tt_out_a: assert property (st_r.fe |-> s_tt_then_out)
		else $error("tip/tilt or output start missing");
	replay_a: assert property (st_r.rp == RP_SEND |=> st_r.ov)
		else $error("wavefront word missing during replay");
	tel_pair_a: assert property (st_r.tv == st_r.ov)
		else $error("telemetry out of step with wavefront");
	xfer_time_a: assert property (st_r.rp == RP_SEND |-> st_r.xc <= 16'(XFER_CYC))
		else $error("frame transfer too long");
	nat_size_a: assert property (st_r.fe && st_r.ctrl[`WCP_C_NAT]
		|-> $past(st_r.pw[SW+2:3]) == SW'(NSUB / 4 - 1))
		else $error("natural-star frame not 32x32");
endmodule : wcp_top

// File: testbench/wcp_cam_model.sv
// camera source model: frames of two-pixel link words
`timescale 1ns/1ps
module wcp_cam_model (
	input  wire logic           aclk,
	output wcp_pkg::wcp_word_type data,
	output logic                valid,
	output logic                fval
);
	import wcp_pkg::*;
	initial begin
		data = 24'h00_0000;
		valid = 1'b0;
		fval = 1'b0;
	end
	// 8 words a subaperture, pixel s+4 in both lanes, a stall before every third word
	task automatic send(input int nsub);
		int w;
		@(posedge aclk);
		for (w = 0; w < nsub * 8; w++) begin
			if (w % 3 == 2) begin
				valid <= 1'b0;
				data <= ~data;
				@(posedge aclk);
			end
			data <= {2{12'(w / 8 + 4)}};
			valid <= 1'b1;
			fval <= 1'b1;
			@(posedge aclk);
		end
		valid <= 1'b0;
		fval <= 1'b0;
		// released word inverted so a stale word never passes for a fresh one
		data <= ~data;
	endtask : send
endmodule : wcp_cam_model

// File: testbench/tb_top.sv
// self-checking bench for the wavefront centroid pipeline
`timescale 1ns/1ps
`include "wcp_params.svh"
module tb_top;
	import wcp_pkg::*;
	logic         aclk = 1'b0;
	logic         aresetn = 1'b0;
	wcp_word_type cam_data, nat_data, wf_data, tel_data, tt_x, tt_y;
	logic         cam_valid, cam_fval, nat_valid, nat_fval, wf_valid, tel_valid, tt_valid;
	logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
	logic [2:0]   awprot = 3'b000, arprot = 3'b000;
	logic [3:0]   wstrb = 4'hf;
	logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0]  wdata = 32'h0000_0000, rdata, d;
	logic         awready, wready, bvalid, arready, rvalid, seen;
	logic [1:0]   bresp, rresp, r;
	int           num_errors = 0, tests_run = 0, i;

	always #2.5 aclk = ~aclk;

	wcp_cam_model cam_m (.aclk(aclk), .data(cam_data), .valid(cam_valid), .fval(cam_fval));
	wcp_cam_model nat_m (.aclk(aclk), .data(nat_data), .valid(nat_valid), .fval(nat_fval));

	// small subaperture count keeps frames short
	wcp_top #(.NSUB(64), .XFER_CYC(5000)) wcp_top_inst (
		.aclk(aclk), .aresetn(aresetn),
		.cam_data(cam_data), .cam_valid(cam_valid), .cam_fval(cam_fval),
		.nat_data(nat_data), .nat_valid(nat_valid), .nat_fval(nat_fval),
		.awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.wf_data(wf_data), .wf_valid(wf_valid), .tel_data(tel_data), .tel_valid(tel_valid),
		.tt_x(tt_x), .tt_y(tt_y), .tt_valid(tt_valid)
	);

	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		int n;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		resp = bresp;
		bready <= 1'b0;
		if (n == 100) num_errors++;
		@(posedge aclk);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		v = rdata;
		check("rresp", {30'h0, rresp}, {30'h0, `WCP_OKAY});
		rready <= 1'b0;
		if (n == 100) num_errors++;
		@(posedge aclk);
	endtask : axi_rd

	// corrected pixel 2(s+1), centroid 32(s+1) less ref 5, mean tt subtracted
	task automatic expect_frame(input int nsub, input int tt, input bit chk_re);
		int n, s;
		logic [11:0] x, re;
		re = 12'h000;
		for (n = 0; n < 4000 && tt_valid !== 1'b1; n++) @(posedge aclk);
		if (n == 4000) num_errors++;
		check("tt_x", {8'h00, tt_x}, {8'h00, 24'(tt)});
		check("tt_y", {8'h00, tt_y}, 32'h0000_0000);
		for (s = 0; s < nsub; s++) begin
			@(posedge aclk);
			x = 12'(32 * (s + 1) - 5 - tt);
			re = re + x;
			check("wf_valid", {31'h0, wf_valid}, 32'h0000_0001);
			check("tel_valid", {31'h0, tel_valid}, 32'h0000_0001);
			check("tel_data", {8'h00, tel_data}, {20'h0_0000, x});
			check("wf_im", {20'h0_0000, wf_data[23:12]}, 32'h0000_0000);
			if (chk_re) check("wf_re", {20'h0_0000, wf_data[11:0]}, {20'h0_0000, re});
		end
		@(posedge aclk);
		check("wf_end", {31'h0, wf_valid}, 32'h0000_0000);
	endtask : expect_frame

	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	initial begin
		#(5 * 60000);
		num_errors++;
		stop_test();
	end

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(`WCP_A_CTRL, d);
		check("ctrl_reset", d, 32'h0000_0002);
		axi_rd(8'hf0, d);
		check("unmapped_rd", d, 32'h0000_0000);
		axi_wr(8'hf0, 32'h0000_0001, r);
		check("unmapped_wr", {30'h0, r}, {30'h0, `WCP_SLVERR});
		wstrb <= 4'h3;
		axi_wr(`WCP_A_THR, 32'h0000_0fff, r);
		wstrb <= 4'hf;
		check("part_wr_resp", {30'h0, r}, {30'h0, `WCP_OKAY});
		axi_rd(`WCP_A_THR, d);
		check("part_wr_thr", d, 32'h0000_0000);
		$display("test registers done");
		axi_wr(`WCP_A_THR, 32'h0000_0000, r);
		// x weight 1 on every pixel gives a plain sum of pixel values
		for (i = 0; i < 16; i++) axi_wr(8'(8'h80 + 4 * i), 32'h0000_0001, r);
		axi_wr(`WCP_A_LIDX, 32'h0000_0000, r);
		for (i = 0; i < 512; i++) axi_wr(`WCP_A_DARK, 32'h0000_3003, r);
		axi_wr(`WCP_A_LIDX, 32'h0000_0000, r);
		for (i = 0; i < 512; i++) axi_wr(`WCP_A_GAIN, 32'h0000_2020, r);
		axi_wr(`WCP_A_LIDX, 32'h0000_0000, r);
		for (i = 0; i < 64; i++) axi_wr(`WCP_A_REF, 32'h0000_0005, r);
		axi_wr(`WCP_A_CTRL, 32'h0000_0001, r);
		fork
			cam_m.send(16);
			expect_frame(16, 267, 1'b1);
		join
		$display("test frame32 done");
		axi_wr(`WCP_A_CAP, 32'h0000_0001, r);
		axi_rd(8'h30, d);
		check("cap_tt", d, 32'h0000_010b);
		axi_rd(`WCP_A_TT, d);
		check("tt_reg", d, 32'h0000_010b);
		axi_rd(`WCP_A_STAT, d);
		check("frame_count", {16'h0000, d[15:0]}, 32'h0000_0001);
		axi_rd(8'h3c, d);
		check("avg_tt", d, 32'h0000_010b);
		axi_rd(8'h38, d);
		check("avg_bg", d, 32'h0000_0b80);
		$display("test capture done");
		axi_wr(`WCP_A_CTRL, 32'h0000_0005, r);
		fork
			nat_m.send(16);
			expect_frame(16, 267, 1'b1);
		join
		seen = 1'b0;
		fork
			cam_m.send(16);
			repeat (300) begin
				@(posedge aclk);
				if (tt_valid === 1'b1) seen = 1'b1;
			end
		join
		check("nat_ignores_cam", {31'h0, seen}, 32'h0000_0000);
		axi_rd(8'h38, d);
		check("avg_bg_again", d, 32'h0000_0b80);
		$display("test natural star done");
		axi_wr(`WCP_A_CTRL, 32'h0000_0003, r);
		fork
			cam_m.send(64);
			expect_frame(64, 1035, 1'b0);
		join
		$display("test frame64 done");
		axi_wr(`WCP_A_FRC, 32'h0000_0123, r);
		axi_wr(`WCP_A_CTRL, 32'h0000_0081, r);
		fork
			cam_m.send(16);
			expect_frame(16, 267, 1'b0);
		join
		axi_wr(`WCP_A_CAP, 32'h0000_0001, r);
		axi_rd(8'h34, d);
		check("cap_wf", d, 32'h0000_0123);
		$display("test force done");
		stop_test();
	end
endmodule : tb_top
